// ---- hdl/pah_device.sv ----
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
module pah_device (
  pah_bus_if.device_mp bus,
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic side_a_edge_input,
  input wire logic side_a_control_line,
  input wire logic side_b_edge_input,
  input wire logic side_b_control_line,
  input wire pah_pkg::pah_byte_t port_a_pins_in,
  input wire pah_pkg::pah_byte_t port_b_pins_in,
  output pah_pkg::pah_byte_t port_a_out,
  output pah_pkg::pah_byte_t port_a_dir,
  output pah_pkg::pah_byte_t port_b_out,
  output pah_pkg::pah_byte_t port_b_dir
);
  import pah_pkg::*;

  typedef struct packed {
    pah_byte_t out;
    pah_byte_t dir;
    pah_ctl_t ctl;
    logic flag1;
    logic flag2;
    logic arm1;
    logic arm2;
    logic prev1;
    logic prev2;
    logic open;
  } pah_side_t;

  typedef struct packed {
    logic e_prev;
    logic sel_cap;
    logic rw_cap;
    logic [1:0] rs_cap;
    pah_byte_t wd_cap;
    pah_byte_t rd;
    pah_side_t [1:0] side;
  } pah_dev_state_t;

  pah_dev_state_t st_reg;
  pah_dev_state_t st_next;
  logic sel_now;
  logic [1:0] rs_now;
  logic [1:0] line1;
  logic [1:0] line2;
  pah_byte_t [1:0] pins;

  assign line1 = {side_b_edge_input, side_a_edge_input};
  assign line2 = {side_b_control_line, side_a_control_line};
  assign pins = {port_b_pins_in, port_a_pins_in};
  assign rs_now = {bus.register_pick_high, bus.register_pick_low};

  assign sel_now = pah_selected(bus.chip_select_high_first, bus.chip_select_high_second,
                                bus.chip_select_low_active);

  function automatic pah_byte_t reg_view(input pah_side_t sd, input logic pick_ctl,
                                         input pah_byte_t pin_val);
    pah_byte_t v;
    if (pick_ctl) begin
      v = {sd.flag1, sd.flag2, sd.ctl};
    end else if (sd.ctl[CTL_ACCESS]) begin
      v = (sd.out & sd.dir) | (pin_val & ~sd.dir);
    end else begin
      v = sd.dir;
    end
    return v;
  endfunction

  // an input is active when it equals its polarity bit
  function automatic logic edge_hit(input logic prev, input logic now, input logic pol);
    return (prev != now) && (now == pol);
  endfunction

  assign bus.dev_d_oe_n = ~(bus.e & sel_now & bus.rw);
  assign bus.dev_d_out = st_reg.rd;

  assign bus.side_a_irq_out = 1'b0;
  assign bus.side_b_irq_out = 1'b0;

  assign bus.side_a_irq_oe_n = ~((st_reg.side[0].flag1 & st_reg.side[0].ctl[CTL_EN1]) |
                                 (st_reg.side[0].flag2 & st_reg.side[0].ctl[CTL_EN2] &
                                  ~st_reg.side[0].ctl[CTL_MODE2]));
  assign bus.side_b_irq_oe_n = ~((st_reg.side[1].flag1 & st_reg.side[1].ctl[CTL_EN1]) |
                                 (st_reg.side[1].flag2 & st_reg.side[1].ctl[CTL_EN2] &
                                  ~st_reg.side[1].ctl[CTL_MODE2]));

  assign port_a_out = st_reg.side[0].out;
  assign port_a_dir = st_reg.side[0].dir;
  assign port_b_out = st_reg.side[1].out;
  assign port_b_dir = st_reg.side[1].dir;

  always_comb begin
    logic efall;
    logic hit1;
    logic hit2;
    logic clr;
    logic wr_go;
    logic in2;
    efall = 1'b0;
    hit1 = 1'b0;
    hit2 = 1'b0;
    clr = 1'b0;
    wr_go = 1'b0;
    in2 = 1'b0;
    st_next = st_reg;

    efall = st_reg.e_prev & ~bus.e;
    st_next.e_prev = bus.e;

    if (bus.e) begin
      st_next.sel_cap = sel_now;
      st_next.rw_cap = bus.rw;
      st_next.rs_cap = rs_now;
      st_next.wd_cap = bus.data_bus;
      st_next.rd = reg_view(st_reg.side[rs_now[RS_PICK_SIDE]], rs_now[RS_PICK_CTL],
                            pins[rs_now[RS_PICK_SIDE]]);
    end

    wr_go = efall & st_reg.sel_cap & ~st_reg.rw_cap;

    for (int s = 0; s < 2; s++) begin
      in2 = ~st_reg.side[s].ctl[CTL_MODE2];
      st_next.side[s].prev1 = line1[s];
      st_next.side[s].prev2 = line2[s];

      if (efall && line1[s] != st_reg.side[s].ctl[CTL_POL1]) begin
        st_next.side[s].arm1 = 1'b1;
      end
      if (efall && line2[s] != st_reg.side[s].ctl[CTL_POL2]) begin
        st_next.side[s].arm2 = 1'b1;
      end

      hit1 = st_reg.side[s].arm1 &
             edge_hit(st_reg.side[s].prev1, line1[s], st_reg.side[s].ctl[CTL_POL1]);
      hit2 = in2 & st_reg.side[s].arm2 &
             edge_hit(st_reg.side[s].prev2, line2[s], st_reg.side[s].ctl[CTL_POL2]);
      if (hit1) begin
        st_next.side[s].arm1 = 1'b0;
      end
      if (hit2) begin
        st_next.side[s].arm2 = 1'b0;
      end

      if (efall && !st_reg.sel_cap) begin
        st_next.side[s].open = 1'b1;
      end

      clr = efall & st_reg.sel_cap & st_reg.rw_cap &
            (st_reg.rs_cap[RS_PICK_SIDE] == 1'(s)) & ~st_reg.rs_cap[RS_PICK_CTL] &
            st_reg.side[s].ctl[CTL_ACCESS];
      if (clr) begin
        st_next.side[s].open = 1'b0;
      end

      // conditioned edge sets
      // a set in the clearing cycle wins
      st_next.side[s].flag1 = (hit1 & st_reg.side[s].open) | (st_reg.side[s].flag1 & ~clr);
      st_next.side[s].flag2 = (hit2 & st_reg.side[s].open) | (st_reg.side[s].flag2 & ~clr);

      if (wr_go && st_reg.rs_cap[RS_PICK_SIDE] == 1'(s)) begin
        if (st_reg.rs_cap[RS_PICK_CTL]) begin
          st_next.side[s].ctl = st_reg.wd_cap[5:0];
        end else if (st_reg.side[s].ctl[CTL_ACCESS]) begin
          st_next.side[s].out = st_reg.wd_cap;
        end else begin
          st_next.side[s].dir = st_reg.wd_cap;
        end
      end
    end

    if (!bus.reset_n) begin
      st_next = '0;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

// ---- include/pah_pkg.sv ----
package pah_pkg;

  typedef logic [7:0] pah_byte_t;
  typedef logic [5:0] pah_ctl_t;

  // control register fields, then register-select bit positions
  localparam int CTL_EN1 = 0;
  localparam int CTL_POL1 = 1;
  localparam int CTL_ACCESS = 2;
  localparam int CTL_EN2 = 3;
  localparam int CTL_POL2 = 4;
  localparam int CTL_MODE2 = 5;
  localparam int RS_PICK_CTL = 0;
  localparam int RS_PICK_SIDE = 1;

  // host-side register map, byte addresses
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_SELECT = 4'h4;
  localparam logic [3:0] OFS_DATA = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;
  localparam logic CONTROL_RST = 1'b1;
  localparam pah_byte_t BUS_IDLE = 8'hff;

  // timing, in ns, and derived cycle counts (least times round up)
  localparam int CLK_PERIOD_NS = 8;
  localparam int T_RESET_RECOVER_NS = 1000;
  localparam int T_ADDR_SETUP_NS = 160;
  localparam int T_E_HIGH_NS = 450;
  localparam int T_E_LOW_NS = 430;
  localparam int T_ADDR_HOLD_NS = 10;
  localparam int T_E_CYCLE_NS = 1000;
  localparam int RECOVER_CYC = (T_RESET_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC = (T_ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HIGH_CYC = (T_E_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOW_CYC = (T_E_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (T_ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYCLE_RAW = (T_E_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYCLE_CYC = (CYCLE_RAW > HIGH_CYC + LOW_CYC) ? CYCLE_RAW : HIGH_CYC + LOW_CYC;
  localparam logic [6:0] E_RISE_AT = 7'(SETUP_CYC);
  localparam logic [6:0] E_FALL_AT = 7'(SETUP_CYC + HIGH_CYC);
  localparam logic [6:0] RELEASE_AT = 7'(SETUP_CYC + HIGH_CYC + HOLD_CYC);
  localparam logic [6:0] CYCLE_LAST = 7'(CYCLE_CYC - 1);
  localparam logic [6:0] RECOVER_LAST = 7'(RECOVER_CYC);

  function automatic logic pah_selected(input logic hi1, input logic hi2, input logic lo_n);
    return hi1 & hi2 & ~lo_n;
  endfunction

endpackage

// ---- include/pah_bus_if.sv ----
`timescale 1ns/1ps
interface pah_bus_if;
  import pah_pkg::*;

  logic e;
  logic rw;
  logic chip_select_high_first;
  logic chip_select_high_second;
  logic chip_select_low_active;
  logic register_pick_low;
  logic register_pick_high;
  logic reset_n;
  pah_byte_t host_d_out;
  logic host_d_oe_n;
  pah_byte_t dev_d_out;
  logic dev_d_oe_n;
  pah_byte_t data_bus;
  logic side_a_irq_out;
  logic side_a_irq_oe_n;
  logic side_b_irq_out;
  logic side_b_irq_oe_n;
  logic side_a_interrupt_out_n;
  logic side_b_interrupt_out_n;

  // undriven bus and request lines float to the pulled-up level
  assign data_bus = !dev_d_oe_n ? dev_d_out : (!host_d_oe_n ? host_d_out : BUS_IDLE);
  assign side_a_interrupt_out_n = side_a_irq_oe_n ? 1'b1 : side_a_irq_out;
  assign side_b_interrupt_out_n = side_b_irq_oe_n ? 1'b1 : side_b_irq_out;

  modport device_mp (
    input e,
    input rw,
    input chip_select_high_first,
    input chip_select_high_second,
    input chip_select_low_active,
    input register_pick_low,
    input register_pick_high,
    input reset_n,
    input data_bus,
    output dev_d_out,
    output dev_d_oe_n,
    output side_a_irq_out,
    output side_a_irq_oe_n,
    output side_b_irq_out,
    output side_b_irq_oe_n
  );

  modport host_mp (
    output e,
    output rw,
    output chip_select_high_first,
    output chip_select_high_second,
    output chip_select_low_active,
    output register_pick_low,
    output register_pick_high,
    output reset_n,
    output host_d_out,
    output host_d_oe_n,
    input data_bus,
    input side_a_interrupt_out_n,
    input side_b_interrupt_out_n
  );
endinterface

// ---- hdl/pah_host.sv ----
`timescale 1ns/1ps
module pah_host (
  pah_bus_if.host_mp bus,
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import pah_pkg::*;

  typedef enum logic [1:0] {
    HS_IDLE,
    HS_PEND,
    HS_ACT,
    HS_DONE
  } pah_hstate_t;

  typedef struct packed {
    pah_hstate_t fsm;
    logic [6:0] phase;
    logic [6:0] recover;
    logic hold_reset;
    logic [1:0] rs;
    logic is_read;
    pah_byte_t wdata;
    pah_byte_t rdata;
  } pah_host_state_t;

  pah_host_state_t st_reg;
  pah_host_state_t st_next;
  logic data_req;
  logic active;
  logic valid_memory_address_qualifier;

  assign data_req = (avs_read | avs_write) && avs_address == OFS_DATA;
  assign active = st_reg.fsm == HS_ACT;

  // free-running enable; idle pulses go out deselected
  assign bus.e = st_reg.phase >= E_RISE_AT && st_reg.phase < E_FALL_AT;
  assign valid_memory_address_qualifier = active;
  assign bus.chip_select_high_first = active;
  assign bus.chip_select_high_second = valid_memory_address_qualifier;
  assign bus.chip_select_low_active = ~active;
  assign bus.register_pick_low = st_reg.rs[0];
  assign bus.register_pick_high = st_reg.rs[1];
  assign bus.rw = ~active | st_reg.is_read;
  assign bus.host_d_out = st_reg.wdata;
  assign bus.host_d_oe_n = ~(active & ~st_reg.is_read);
  assign bus.reset_n = ~st_reg.hold_reset;

  always_comb begin
    avs_waitrequest = 1'b0;
    avs_readdata = 32'h0;
    if (data_req) begin
      avs_waitrequest = st_reg.fsm != HS_DONE;
    end
    unique case (avs_address)
      OFS_CONTROL: avs_readdata = {31'h0, st_reg.hold_reset};
      OFS_SELECT: avs_readdata = {30'h0, st_reg.rs};
      OFS_DATA: avs_readdata = {24'h0, st_reg.rdata};
      OFS_STATUS: avs_readdata = {29'h0, st_reg.recover == RECOVER_LAST,
                                  ~bus.side_b_interrupt_out_n, ~bus.side_a_interrupt_out_n};
      default: avs_readdata = 32'h0;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    st_next.phase = (st_reg.phase == CYCLE_LAST) ? 7'h0 : st_reg.phase + 7'h1;

    if (avs_write && avs_address == OFS_CONTROL) begin
      st_next.hold_reset = avs_writedata[0];
    end
    if (avs_write && avs_address == OFS_SELECT && st_reg.fsm == HS_IDLE) begin
      st_next.rs = avs_writedata[1:0];
    end

    if (st_reg.hold_reset) begin
      st_next.recover = 7'h0;
    end else if (st_reg.recover != RECOVER_LAST) begin
      st_next.recover = st_reg.recover + 7'h1;
    end

    unique case (st_reg.fsm)
      HS_IDLE: begin
        if (data_req && !st_reg.hold_reset && st_reg.recover == RECOVER_LAST) begin
          st_next.fsm = HS_PEND;
          st_next.is_read = avs_read;
          st_next.wdata = avs_writedata[7:0];
        end
      end
      HS_PEND: begin
        if (st_reg.phase == CYCLE_LAST) begin
          st_next.fsm = HS_ACT;
        end
      end
      HS_ACT: begin
        // sample on the last enable-high cycle
        if (st_reg.phase == E_FALL_AT - 7'h1 && st_reg.is_read) begin
          st_next.rdata = bus.data_bus;
        end
        if (st_reg.phase == RELEASE_AT - 7'h1) begin
          st_next.fsm = HS_DONE;
        end
      end
      HS_DONE: begin
        st_next.fsm = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '{fsm: HS_IDLE, phase: 7'h0, recover: 7'h0, hold_reset: CONTROL_RST,
                  rs: 2'h0, is_read: 1'b0, wdata: 8'h0, rdata: 8'h0};
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

// ---- verification/pah_properties.sv ----
`timescale 1ns/1ps
module pah_properties (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic e,
  input wire logic rw,
  input wire logic chip_select_high_first,
  input wire logic chip_select_high_second,
  input wire logic chip_select_low_active,
  input wire logic register_pick_low,
  input wire logic register_pick_high,
  input wire logic reset_n,
  input wire logic host_d_oe_n,
  input wire logic dev_d_oe_n,
  input wire logic side_a_irq_out,
  input wire logic side_a_irq_oe_n,
  input wire logic side_b_irq_out,
  input wire logic side_b_irq_oe_n
);
  import pah_pkg::*;
  logic sel;
  logic [5:0] addr_lines;
  logic [7:0] hi_cnt_reg;
  logic [7:0] rec_cnt_reg;
  assign sel = chip_select_high_first & chip_select_high_second & ~chip_select_low_active;
  assign addr_lines = {chip_select_high_first, chip_select_high_second,
    chip_select_low_active, register_pick_high, register_pick_low, rw};

  // recovery count saturates at 128, enough to cover the 125-cycle minimum
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hi_cnt_reg <= 8'h00;
      rec_cnt_reg <= 8'h00;
    end else begin
      hi_cnt_reg <= e ? hi_cnt_reg + 8'h01 : 8'h00;
      rec_cnt_reg <= !reset_n ? 8'h00 : (rec_cnt_reg[7] ? rec_cnt_reg : rec_cnt_reg + 8'h01);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  no_stray_drive_a:
    assert property (!dev_d_oe_n |-> e && sel && rw) else $error("device drives bus idle");
  read_drives_a:
    assert property (e && sel && rw && reset_n |-> !dev_d_oe_n) else $error("read not driven");
  host_write_a:
    assert property (!host_d_oe_n |-> sel && !rw) else $error("host drives outside write");
  // idle pulses go out deselected, so the host may move register picks then
  sel_stable_a:
    assert property (e && $past(e) && (sel || $past(sel)) |-> $stable(addr_lines))
    else $error("selects moved in pulse");
  addr_setup_a:
    assert property ($rose(e) && sel |-> $past(sel, 20) && $past(rw, 20) == rw)
    else $error("select setup too short");
  addr_hold_a:
    assert property ($fell(e) && sel |-> sel [*2]) else $error("select hold too short");
  pulse_width_a:
    assert property ($fell(e) |-> hi_cnt_reg >= 8'(HIGH_CYC)) else $error("enable pulse short");
  recover_wait_a:
    assert property (e && sel |-> rec_cnt_reg >= 8'(RECOVER_CYC))
    else $error("access too soon after reset");
  open_drain_a:
    assert property ((!side_a_irq_oe_n |-> !side_a_irq_out) and
                     (!side_b_irq_oe_n |-> !side_b_irq_out))
    else $error("request pin driven high");
  reset_irq_a:
    assert property (!reset_n |=> side_a_irq_oe_n && side_b_irq_oe_n)
    else $error("request held in reset");
endmodule

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import pah_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] ein = 2'h3;
  logic [1:0] cin = 2'h3;
  pah_byte_t pin_m [2] = '{8'h00, 8'h00};
  pah_byte_t port_out [2];
  pah_byte_t port_dir [2];
  int ctl_m [2] = '{0, 0};
  int ddr_m [2] = '{0, 0};
  int out_m [2] = '{0, 0};
  int fl_m [2] = '{0, 0};
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [31:0] rd;

  pah_bus_if bus ();
  pah_host pah_host_inst (.bus(bus), .ref_clk(ref_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  pah_device pah_device_inst (.bus(bus), .ref_clk(ref_clk), .sys_rst(sys_rst),
    .side_a_edge_input(ein[0]), .side_a_control_line(cin[0]),
    .side_b_edge_input(ein[1]), .side_b_control_line(cin[1]),
    .port_a_pins_in(pin_m[0]), .port_b_pins_in(pin_m[1]),
    .port_a_out(port_out[0]), .port_a_dir(port_dir[0]),
    .port_b_out(port_out[1]), .port_b_dir(port_dir[1]));
  pah_properties pah_properties_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .e(bus.e),
    .rw(bus.rw), .chip_select_high_first(bus.chip_select_high_first),
    .chip_select_high_second(bus.chip_select_high_second),
    .chip_select_low_active(bus.chip_select_low_active),
    .register_pick_low(bus.register_pick_low), .register_pick_high(bus.register_pick_high),
    .reset_n(bus.reset_n), .host_d_oe_n(bus.host_d_oe_n), .dev_d_oe_n(bus.dev_d_oe_n),
    .side_a_irq_out(bus.side_a_irq_out), .side_a_irq_oe_n(bus.side_a_irq_oe_n),
    .side_b_irq_out(bus.side_b_irq_out), .side_b_irq_oe_n(bus.side_b_irq_oe_n));

  always #4 ref_clk = ~ref_clk;

  task automatic report_and_stop();
    $display("errors %0d, comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // run is about 12k cycles; a stuck wait ends here
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic chk8(input pah_byte_t got, input pah_byte_t exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t: byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t: bit %b expected %b", $time, got, exp);
    end
  endtask

  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rwr(input int c, input int v);
    int s;
    s = c / 2;
    v = v & 'hff;
    av(1'b1, OFS_SELECT, 32'(c));
    av(1'b1, OFS_DATA, 32'(v));
    if (c % 2) ctl_m[s] = v & 'h3f;
    else if (ctl_m[s] & 4) out_m[s] = v;
    else ddr_m[s] = v;
  endtask

  task automatic rrd(input int c);
    int s;
    int x;
    s = c / 2;
    av(1'b1, OFS_SELECT, 32'(c));
    av(1'b0, OFS_DATA, 32'h0);
    if (c % 2) x = ctl_m[s] | fl_m[s];
    else if (ctl_m[s] & 4) begin
      x = pin_m[s];
      fl_m[s] = 0;
    end else x = ddr_m[s];
    chk8(rd[7:0], 8'(x));
  endtask

  task automatic chk_irq(input int s);
    int c;
    c = ctl_m[s];
    chk1(s ? bus.side_b_interrupt_out_n : bus.side_a_interrupt_out_n,
      !(((fl_m[s] & 'h80) && (c & 1)) || ((fl_m[s] & 'h40) && (c & 8) && !(c & 'h20))));
  endtask

  task automatic set_line(input int s, input int ln, input int v);
    if (ln) cin[s] <= v[0];
    else ein[s] <= v[0];
  endtask

  initial begin
    rd = $urandom(1);
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    av(1'b0, OFS_CONTROL, 32'h0);
    chk8(rd[7:0], 8'(CONTROL_RST));
    av(1'b0, 4'h2, 32'h0);
    chk8(rd[7:0], 8'h00);
    av(1'b1, OFS_CONTROL, 32'h0);
    for (int c = 0; c < 4; c++) rrd(c);
    av(1'b0, OFS_STATUS, 32'h0);
    chk1(rd[2], 1'b1);
    for (int s = 0; s < 2; s++) begin
      rwr(2 * s, $urandom);
      rwr(2 * s + 1, 'hff);
      rrd(2 * s + 1);
      rwr(2 * s + 1, 4);
      rwr(2 * s, $urandom);
      pin_m[s] <= 8'((out_m[s] & ddr_m[s]) | ($urandom & ~ddr_m[s]));
      chk8(port_out[s], 8'(out_m[s]));
      chk8(port_dir[s], 8'(ddr_m[s]));
      rrd(2 * s);
    end
    // every side, line and edge; enable alternates per pair
    for (int k = 0; k < 8; k++) begin
      int s;
      int ln;
      int p;
      int en;
      int m;
      s = k % 2;
      ln = (k / 2) % 2;
      p = k / 4;
      en = (k ^ (k >> 1) ^ (k >> 2)) & 1;
      m = ln ? 'h40 : 'h80;
      set_line(s, ln, !p);
      rwr(2 * s + 1, 4 | (ln ? (en << 3) | (p << 4) : en | (p << 1)));
      repeat (260) @(posedge ref_clk);
      rrd(2 * s);
      repeat (260) @(posedge ref_clk);
      set_line(s, ln, p);
      repeat (3) @(posedge ref_clk);
      fl_m[s] = fl_m[s] | m;
      chk_irq(s);
      rrd(2 * s + 1);
      rrd(2 * s);
      chk_irq(s);
      set_line(s, ln, !p);
      repeat (2) @(posedge ref_clk);
      set_line(s, ln, p);
      repeat (3) @(posedge ref_clk);
      chk_irq(s);
      rrd(2 * s + 1);
      set_line(s, ln, 1);
      @(posedge ref_clk);
    end
    // master reset in mid-run must zero the device again
    av(1'b1, OFS_CONTROL, 32'h1);
    av(1'b1, OFS_CONTROL, 32'h0);
    for (int s = 0; s < 2; s++) begin
      ctl_m[s] = 0;
      ddr_m[s] = 0;
      out_m[s] = 0;
      fl_m[s] = 0;
      chk8(port_out[s], 8'h00);
      chk8(port_dir[s], 8'h00);
    end
    for (int c = 0; c < 4; c++) rrd(c);
    report_and_stop();
  end
endmodule
